// File: hdl/i2cst_defines.svh
// register offsets, field positions and reset values of the status block
`ifndef I2CST_DEFINES_SVH
`define I2CST_DEFINES_SVH

`define I2CST_OFF_STATUS 8'h00
`define I2CST_OFF_STATE 8'h04
`define I2CST_OFF_TXCNT 8'h08
`define I2CST_OFF_RXCNT 8'h0C
`define I2CST_OFF_INTERRUPT_ENABLE_MASK 8'h10
`define I2CST_OFF_IRQ_RAW 8'h14
`define I2CST_OFF_IRQ_END 8'h18
`define I2CST_OFF_IRQ_CLR 8'h1C
`define I2CST_OFF_RX_TRG 8'h20
`define I2CST_OFF_TX_TRG 8'h24

`define I2CST_CNT_MAX 11'h7FE
`define I2CST_CNT_RST 11'h000
`define I2CST_TRG_RST 5'h08
`define I2CST_ENB_RST 16'h0000

`define I2CST_B_BUSQ 0
`define I2CST_B_IDLE 1
`define I2CST_B_WAIT 2
`define I2CST_B_STALL 3
`define I2CST_B_ARB 4
`define I2CST_B_NACKA 5
`define I2CST_B_NACKD 6
`define I2CST_B_CLKLO 7
`define I2CST_B_RXNE 8
`define I2CST_B_INBOUND_QUEUE_SATURATED 9
`define I2CST_B_TXOVF 10
`define I2CST_B_RXTRG 11
`define I2CST_B_RXOVF 11
`define I2CST_B_OUTBOUND_QUEUE_DRAINED 12
`define I2CST_B_TXRDY 12
`define I2CST_B_TXNF 13
`define I2CST_B_RXRDY 13
`define I2CST_B_TXTRG 15
`define I2CST_B_IRQ_TXE 14
`define I2CST_B_IRQ_RXF 15
`define I2CST_B_SDA 30
`define I2CST_B_SCL 31

`endif

// File: hdl/i2cst_pkg.sv
// types shared by the status and interrupt block
package i2cst_pkg;

  typedef enum logic [1:0] {
    I2CST_BUS_QUIET = 2'b01,
    I2CST_BUS_BUSY = 2'b10
  } i2cst_bus_t;

  // events and levels reported by the controller core, same clock
  typedef struct packed {
    logic ctrl_idle;
    logic txn_start;
    logic txn_held;
    logic stop_sent;
    logic tx_active;
    logic rx_active;
    logic arb_lost;
    logic nack_addr;
    logic nack_data;
    logic word_sent;
    logic word_rcvd;
    logic clock_low_expiry;
    logic outbound_overrun;
    logic inbound_overrun;
  } i2cst_evt_t;

  typedef struct packed {
    logic [3:0] state;
    logic [3:0] step;
    logic [8:0] bit_engine_state;
    logic [4:0] rx_level;
    logic [4:0] tx_level;
  } i2cst_obs_t;

endpackage : i2cst_pkg

// File: hdl/i2cst_sync.sv
// two flip-flop synchroniser for pin levels
`timescale 1ns/10ps
module i2cst_sync #(
  parameter int W = 2,
  parameter logic [W-1:0] INIT = '1
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      meta_reg <= INIT;
      sync_out <= INIT;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule : i2cst_sync

// File: hdl/i2cst_top.sv
// status, tallies and interrupt logic of the two-wire bus master
`timescale 1ns/10ps
`include "i2cst_defines.svh"
module i2cst_top
  import i2cst_pkg::*;
#(
  parameter logic [4:0] FIFO_DEPTH = 5'h10
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire i2cst_evt_t evt,
  input wire i2cst_obs_t obs,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic irq
);

  // ***************************************************************
  // pin sampling and bus quiet detection
  // ***************************************************************
  logic [1:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic sda_d_reg;
  logic bus_start;
  logic bus_stop;
  i2cst_bus_t bus_reg;
  logic bus_quiet_flag;

  i2cst_sync #(
    .W(2),
    .INIT(2'h3)
  ) u_sync (
    .sys_clk(sys_clk),
    .srst(srst),
    .async_in({scl_in, sda_in}),
    .sync_out(pins_s)
  );

  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sda_d_reg <= 1'b1;
    end else begin
      sda_d_reg <= sda_s;
    end
  end

  assign bus_start = scl_s & sda_d_reg & ~sda_s;
  assign bus_stop = scl_s & ~sda_d_reg & sda_s;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      bus_reg <= I2CST_BUS_QUIET;
    end else begin
      case (bus_reg)
        I2CST_BUS_QUIET: begin
          if (bus_start) begin
            bus_reg <= I2CST_BUS_BUSY;
          end
        end
        I2CST_BUS_BUSY: begin
          if (bus_stop) begin
            bus_reg <= I2CST_BUS_QUIET;
          end
        end
        default: begin
          bus_reg <= I2CST_BUS_QUIET;
        end
      endcase
    end
  end

  assign bus_quiet_flag = (bus_reg == I2CST_BUS_QUIET);

  // ***************************************************************
  // transaction status flags
  // ***************************************************************
  logic waiting_reg;
  logic arbitration_defeat_flag;
  logic address_refused_flag;
  logic word_refused_flag;
  logic stalled;

  function automatic logic hold_flag(input logic set, input logic clr,
                                     input logic cur);
    hold_flag = set ? 1'b1 : (clr ? 1'b0 : cur);
  endfunction : hold_flag

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      waiting_reg <= 1'b0;
    end else begin
      waiting_reg <= hold_flag(evt.txn_held,
                               evt.txn_start | evt.stop_sent,
                               waiting_reg);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      arbitration_defeat_flag <= 1'b0;
      address_refused_flag <= 1'b0;
      word_refused_flag <= 1'b0;
    end else begin
      arbitration_defeat_flag <= hold_flag(evt.arb_lost, evt.txn_start,
                                           arbitration_defeat_flag);
      address_refused_flag <= hold_flag(evt.nack_addr, evt.txn_start,
                                        address_refused_flag);
      word_refused_flag <= hold_flag(evt.nack_data, evt.txn_start,
                                     word_refused_flag);
    end
  end

  // ***************************************************************
  // queue flags
  // ***************************************************************
  logic [4:0] rx_trg_reg;
  logic [4:0] tx_trg_reg;
  logic inbound_has_entries;
  logic inbound_queue_saturated;
  logic inbound_level_reached;
  logic outbound_queue_drained;
  logic outbound_has_room;
  logic outbound_level_low;

  assign inbound_has_entries = (obs.rx_level != 5'h00);
  assign inbound_queue_saturated = (obs.rx_level >= FIFO_DEPTH);
  assign inbound_level_reached = (obs.rx_level >= rx_trg_reg);
  assign outbound_queue_drained = (obs.tx_level == 5'h00);
  assign outbound_has_room = (obs.tx_level < FIFO_DEPTH);
  assign outbound_level_low = (obs.tx_level < tx_trg_reg);

  assign stalled = (evt.tx_active & outbound_queue_drained) |
                   (evt.rx_active & inbound_queue_saturated);

  logic [31:0] status_now;

  always_comb begin
    status_now = 32'h0000_0000;
    status_now[`I2CST_B_BUSQ] = bus_quiet_flag;
    status_now[`I2CST_B_IDLE] = evt.ctrl_idle;
    status_now[`I2CST_B_WAIT] = waiting_reg;
    status_now[`I2CST_B_STALL] = stalled;
    status_now[`I2CST_B_ARB] = arbitration_defeat_flag;
    status_now[`I2CST_B_NACKA] = address_refused_flag;
    status_now[`I2CST_B_NACKD] = word_refused_flag;
    status_now[`I2CST_B_RXNE] = inbound_has_entries;
    status_now[`I2CST_B_INBOUND_QUEUE_SATURATED] = inbound_queue_saturated;
    status_now[`I2CST_B_RXTRG] = inbound_level_reached;
    status_now[`I2CST_B_OUTBOUND_QUEUE_DRAINED] = outbound_queue_drained;
    status_now[`I2CST_B_TXNF] = outbound_has_room;
    status_now[`I2CST_B_TXTRG] = outbound_level_low;
    status_now[`I2CST_B_SDA] = sda_s;
    status_now[`I2CST_B_SCL] = scl_s;
  end

  // ***************************************************************
  // word tallies
  // ***************************************************************
  logic [10:0] sent_word_tally;
  logic [10:0] received_word_tally;

  function automatic logic [10:0] tally_next(input logic start,
                                             input logic word,
                                             input logic [10:0] cur);
    logic [10:0] base;
    base = start ? `I2CST_CNT_RST : cur;
    if (word && base < `I2CST_CNT_MAX) begin
      tally_next = base + 11'h001;
    end else begin
      tally_next = base;
    end
  endfunction : tally_next

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sent_word_tally <= `I2CST_CNT_RST;
    end else begin
      sent_word_tally <= tally_next(evt.txn_start, evt.word_sent,
                                    sent_word_tally);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      received_word_tally <= `I2CST_CNT_RST;
    end else begin
      received_word_tally <= tally_next(evt.txn_start, evt.word_rcvd,
                                        received_word_tally);
    end
  end

  // ***************************************************************
  // interrupt sources
  // ***************************************************************
  logic [6:0] status_prev_reg;
  logic [6:0] edge_reg;
  logic clk_lo_reg;
  logic tx_ovf_reg;
  logic rx_ovf_reg;
  logic [15:0] interrupt_enable_mask;
  logic [15:0] irq_raw;
  logic [15:0] irq_end;
  logic clr_wr;

  assign clr_wr = reg_wr && (reg_addr == `I2CST_OFF_IRQ_CLR);

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      status_prev_reg <= 7'h03;
      edge_reg <= 7'h00;
    end else begin
      status_prev_reg <= status_now[6:0];
      edge_reg <= status_now[6:0] & ~status_prev_reg;
    end
  end

  // a new event wins over a clear in the same cycle
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      clk_lo_reg <= 1'b0;
      tx_ovf_reg <= 1'b0;
      rx_ovf_reg <= 1'b0;
    end else begin
      clk_lo_reg <= hold_flag(evt.clock_low_expiry,
                              clr_wr & reg_wdata[`I2CST_B_CLKLO],
                              clk_lo_reg);
      tx_ovf_reg <= hold_flag(evt.outbound_overrun,
                              clr_wr & reg_wdata[`I2CST_B_TXOVF],
                              tx_ovf_reg);
      rx_ovf_reg <= hold_flag(evt.inbound_overrun,
                              clr_wr & reg_wdata[`I2CST_B_RXOVF],
                              rx_ovf_reg);
    end
  end

  always_comb begin
    irq_raw = 16'h0000;
    irq_raw[6:0] = edge_reg;
    irq_raw[`I2CST_B_CLKLO] = clk_lo_reg;
    irq_raw[`I2CST_B_TXOVF] = tx_ovf_reg;
    irq_raw[`I2CST_B_RXOVF] = rx_ovf_reg;
    irq_raw[`I2CST_B_TXRDY] = outbound_level_low;
    irq_raw[`I2CST_B_RXRDY] = inbound_level_reached;
    irq_raw[`I2CST_B_IRQ_TXE] = outbound_queue_drained;
    irq_raw[`I2CST_B_IRQ_RXF] = inbound_queue_saturated;
  end

  assign irq_end = irq_raw & interrupt_enable_mask;
  assign irq = |irq_end;

  // ***************************************************************
  // register port
  // ***************************************************************
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      interrupt_enable_mask <= `I2CST_ENB_RST;
      rx_trg_reg <= `I2CST_TRG_RST;
      tx_trg_reg <= `I2CST_TRG_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        `I2CST_OFF_INTERRUPT_ENABLE_MASK: begin
          interrupt_enable_mask <= reg_wdata[15:0];
        end
        `I2CST_OFF_RX_TRG: begin
          rx_trg_reg <= reg_wdata[4:0];
        end
        `I2CST_OFF_TX_TRG: begin
          tx_trg_reg <= reg_wdata[4:0];
        end
        default: begin
        end
      endcase
    end
  end

  logic [31:0] rdata_next;

  always_comb begin
    case (reg_addr)
      `I2CST_OFF_STATUS: rdata_next = status_now;
      `I2CST_OFF_STATE: rdata_next = {3'h0, obs.bit_engine_state, 1'b0,
                                      obs.tx_level, 1'b0, obs.rx_level,
                                      obs.step, obs.state};
      `I2CST_OFF_TXCNT: rdata_next = {21'h000000, sent_word_tally};
      `I2CST_OFF_RXCNT: rdata_next = {21'h000000, received_word_tally};
      `I2CST_OFF_INTERRUPT_ENABLE_MASK: rdata_next = {16'h0000, interrupt_enable_mask};
      `I2CST_OFF_IRQ_RAW: rdata_next = {16'h0000, irq_raw};
      `I2CST_OFF_IRQ_END: rdata_next = {16'h0000, irq_end};
      `I2CST_OFF_RX_TRG: rdata_next = {27'h0000000, rx_trg_reg};
      `I2CST_OFF_TX_TRG: rdata_next = {27'h0000000, tx_trg_reg};
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      reg_rdata <= rdata_next;
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // ***************************************************************
  // assertions
  // ***************************************************************
  sequence s_bus_start;
    bus_start && bus_quiet_flag;
  endsequence

  sequence s_bus_stop;
    bus_stop && !bus_quiet_flag;
  endsequence

  property p_bus_quiet;
    @(posedge sys_clk) disable iff (srst)
      s_bus_start |=> !status_now[`I2CST_B_BUSQ] ##1
      (!status_now[`I2CST_B_BUSQ] || $past(bus_stop));
  endproperty
  a_bus_quiet: assert property (p_bus_quiet)
    else $error("bus quiet flag did not drop on start");

  property p_bus_release;
    @(posedge sys_clk) disable iff (srst)
      s_bus_stop |=> status_now[`I2CST_B_BUSQ];
  endproperty
  a_bus_release: assert property (p_bus_release)
    else $error("bus quiet flag did not rise on stop");

  property p_idle_read;
    @(posedge sys_clk) disable iff (srst)
      (reg_rd && reg_addr == `I2CST_OFF_STATUS) |=>
      reg_rdata[`I2CST_B_IDLE] == $past(evt.ctrl_idle);
  endproperty
  a_idle_read: assert property (p_idle_read)
    else $error("controller idle bit read back wrong");

  property p_waiting;
    @(posedge sys_clk) disable iff (srst)
      evt.txn_held |=> waiting_reg ##1
      (waiting_reg || $past(evt.txn_start || evt.stop_sent));
  endproperty
  a_waiting: assert property (p_waiting)
    else $error("waiting flag not held after held transaction");

  property p_stall;
    @(posedge sys_clk) disable iff (srst)
      (evt.tx_active && obs.tx_level == 5'h00) |->
      status_now[`I2CST_B_STALL];
  endproperty
  a_stall: assert property (p_stall)
    else $error("stall not shown with empty outbound queue");

  property p_arb;
    @(posedge sys_clk) disable iff (srst)
      evt.arb_lost |=> arbitration_defeat_flag [*2] or
      (arbitration_defeat_flag ##1 $past(evt.txn_start));
  endproperty
  a_arb: assert property (p_arb)
    else $error("arbitration loss not latched");

  property p_nack_addr;
    @(posedge sys_clk) disable iff (srst)
      (evt.nack_addr || evt.nack_data) |=>
      (address_refused_flag || word_refused_flag);
  endproperty
  a_nack_addr: assert property (p_nack_addr)
    else $error("refusal not latched");

  property p_rx_full;
    @(posedge sys_clk) disable iff (srst)
      (reg_rd && reg_addr == `I2CST_OFF_STATUS) |=>
      reg_rdata[`I2CST_B_INBOUND_QUEUE_SATURATED] == ($past(obs.rx_level) >= FIFO_DEPTH);
  endproperty
  a_rx_full: assert property (p_rx_full)
    else $error("inbound full bit wrong");

  property p_state;
    @(posedge sys_clk) disable iff (srst)
      (reg_rd && reg_addr == `I2CST_OFF_STATE) |=>
      reg_rdata[18:14] == $past(obs.tx_level) &&
      reg_rdata[12:8] == $past(obs.rx_level);
  endproperty
  a_state: assert property (p_state)
    else $error("state word levels wrong");

  property p_tally_inc;
    @(posedge sys_clk) disable iff (srst)
      (evt.word_sent && !evt.txn_start &&
       sent_word_tally < `I2CST_CNT_MAX) |=>
      sent_word_tally == $past(sent_word_tally) + 11'h001;
  endproperty
  a_tally_inc: assert property (p_tally_inc)
    else $error("sent tally did not count");

  property p_tally_sat;
    @(posedge sys_clk) disable iff (srst)
      (received_word_tally == `I2CST_CNT_MAX && !evt.txn_start) |=>
      received_word_tally == `I2CST_CNT_MAX;
  endproperty
  a_tally_sat: assert property (p_tally_sat)
    else $error("received tally passed its limit");

  sequence s_arb_rise;
    !status_now[`I2CST_B_ARB] ##1 status_now[`I2CST_B_ARB];
  endsequence

  property p_edge_irq;
    @(posedge sys_clk) disable iff (srst)
      s_arb_rise ##0 interrupt_enable_mask[`I2CST_B_ARB] |=> irq ##1
      !irq_raw[`I2CST_B_ARB];
  endproperty
  a_edge_irq: assert property (p_edge_irq)
    else $error("edge interrupt not a single pulse");

  property p_clear;
    @(posedge sys_clk) disable iff (srst)
      (clr_wr && reg_wdata[`I2CST_B_TXOVF] && !evt.outbound_overrun) |=>
      !irq_raw[`I2CST_B_TXOVF];
  endproperty
  a_clear: assert property (p_clear)
    else $error("overrun not cleared");

  property p_irq_mask;
    @(posedge sys_clk) disable iff (srst)
      (interrupt_enable_mask == 16'h0000) |-> !irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask)
    else $error("interrupt raised with all sources masked");

endmodule : i2cst_top

// File: verification/i2cst_bus_model.sv
// far-side two-wire bus party that frames start and stop on the pins
`timescale 1ns/10ps
module i2cst_bus_model (
  output logic scl,
  output logic sda
);
  // half of the 200 ns link clock period
  localparam int HALF = 100;
  // ****
  // idle: pull-ups hold both lines high, clock stands still
  // ****
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // start: data falls while clock is high, then clock pulses
  task automatic frame_open(input int pulses);
    #7;
    sda = 1'b0;
    #(HALF);
    for (int i = 0; i < pulses; i++) begin
      scl = 1'b0;
      #(HALF);
      scl = 1'b1;
      #(HALF);
    end
  endtask : frame_open
  // stop: data rises while clock is high
  task automatic frame_close();
    sda = 1'b1;
    #(HALF);
  endtask : frame_close
endmodule : i2cst_bus_model

// File: verification/i2cst_top_tb.sv
// self-checking bench for the status, tally and interrupt block
`timescale 1ns/10ps
module i2cst_top_tb;
  import i2cst_pkg::*;
  // ****
  // signals
  // ****
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  i2cst_evt_t evt = 14'h2000;
  i2cst_obs_t obs = '0;
  logic scl;
  logic sda;
  logic irq;
  logic [31:0] d;
  int mismatches = 0;
  int num_checks = 0;
  int irq_hits = 0;
  localparam logic [13:0] E_IDLE = 14'h2000;
  localparam logic [13:0] E_START = 14'h1000;
  localparam logic [13:0] E_HELD = 14'h0800;
  localparam logic [13:0] E_STOP = 14'h0400;
  localparam logic [13:0] E_TXA = 14'h0200;
  localparam logic [13:0] E_RXA = 14'h0100;
  localparam logic [13:0] E_ARB = 14'h0080;
  localparam logic [13:0] E_NA = 14'h0040;
  localparam logic [13:0] E_ND = 14'h0020;
  localparam logic [13:0] E_WS = 14'h0010;
  localparam logic [13:0] E_WR = 14'h0008;
  localparam logic [13:0] E_CLK = 14'h0004;
  localparam logic [13:0] E_TOVF = 14'h0002;
  localparam logic [13:0] E_ROVF = 14'h0001;
  always #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (irq === 1'b1) irq_hits <= irq_hits + 1;
  i2cst_top #(.FIFO_DEPTH(5'h10)) uut (.sys_clk(sys_clk), .srst(srst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .evt(evt), .obs(obs),
    .scl_in(scl), .sda_in(sda), .irq(irq));
  i2cst_bus_model bus (.scl(scl), .sda(sda));
  // ****
  // bus cycles and compares
  // ****
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  task automatic pulse(input logic [13:0] m);
    @(posedge sys_clk);
    evt <= evt | m;
    @(posedge sys_clk);
    evt <= evt & ~m;
    #1;
  endtask : pulse
  // ****
  // scenarios
  // ****
  task automatic t_reset();
    rd(8'h00);
    chk(d, 32'hC000B003);
    wr(8'h00, 32'h0);
    rd(8'h00);
    chk(d, 32'hC000B003);
    rd(8'h08);
    chk(d, 32'h0);
    rd(8'h0C);
    chk(d, 32'h0);
    rd(8'h40);
    chk(d, 32'h0);
    chk(32'(irq), 32'h0);
    $display("test reset done");
  endtask : t_reset
  task automatic t_fifo();
    logic [4:0] tx [3] = '{5'h03, 5'h10, 5'h08};
    logic [4:0] rx [3] = '{5'h0C, 5'h10, 5'h07};
    logic [31:0] ex [3] = '{32'hA900, 32'h0B00, 32'h2100};
    for (int i = 0; i < 3; i++) begin
      @(posedge sys_clk);
      obs <= '{4'h5, 4'hA, 9'h1B3, rx[i], tx[i]};
      rd(8'h04);
      chk(d, {3'h0, 9'h1B3, 1'b0, tx[i], 1'b0, rx[i], 8'hA5});
      rd(8'h00);
      chk(d & 32'hBB00, ex[i]);
    end
    wr(8'h20, 32'h0000000D);
    wr(8'h24, 32'h00000002);
    obs <= '{4'h0, 4'h0, 9'h000, 5'h0C, 5'h03};
    rd(8'h20);
    chk(d, 32'h0000000D);
    rd(8'h00);
    chk(d & 32'h8800, 32'h0);
    wr(8'h20, 32'h00000008);
    wr(8'h24, 32'h00000008);
    @(posedge sys_clk);
    obs <= '0;
    $display("test fifo done");
  endtask : t_fifo
  task automatic t_events();
    logic [13:0] m [4] = '{E_HELD, E_ARB, E_NA, E_ND};
    int b [4] = '{2, 4, 5, 6};
    wr(8'h10, 32'h7F);
    for (int i = 0; i < 4; i++) begin
      irq_hits = 0;
      pulse(m[i]);
      rd(8'h00);
      chk(32'(d[b[i]]), 32'h1);
      chk(32'(irq_hits), 32'h1);
      chk(32'(irq), 32'h0);
    end
    pulse(E_START);
    rd(8'h00);
    chk(d & 32'h74, 32'h0);
    pulse(E_HELD);
    pulse(E_STOP);
    rd(8'h00);
    chk(32'(d[2]), 32'h0);
    @(posedge sys_clk);
    evt <= evt | E_TXA;
    rd(8'h00);
    chk(32'(d[3]), 32'h1);
    evt <= evt & ~E_TXA | E_RXA;
    obs.rx_level <= 5'h10;
    rd(8'h00);
    chk(32'(d[3]), 32'h1);
    obs.rx_level <= 5'h05;
    rd(8'h00);
    chk(32'(d[3]), 32'h0);
    evt <= evt & ~E_RXA & ~E_IDLE;
    rd(8'h00);
    chk(32'(d[1]), 32'h0);
    evt <= evt | E_IDLE;
    obs <= '0;
    wr(8'h10, 32'h0);
    $display("test events done");
  endtask : t_events
  task automatic t_tally();
    pulse(E_START);
    repeat (5) pulse(E_WS);
    rd(8'h08);
    chk(d, 32'h5);
    pulse(E_START | E_WS);
    rd(8'h08);
    chk(d, 32'h1);
    pulse(E_START);
    @(posedge sys_clk);
    evt <= evt | E_WR;
    repeat (2050) @(posedge sys_clk);
    evt <= evt & ~E_WR;
    rd(8'h0C);
    chk(d, 32'h7FE);
    rd(8'h08);
    chk(d, 32'h0);
    $display("test tally done");
  endtask : t_tally
  task automatic t_link();
    bus.frame_open(4);
    repeat (4) @(posedge sys_clk);
    rd(8'h00);
    chk(d & 32'hC0000001, 32'h80000000);
    bus.frame_close();
    repeat (4) @(posedge sys_clk);
    rd(8'h00);
    chk(d & 32'hC0000001, 32'hC0000001);
    $display("test link done");
  endtask : t_link
  task automatic t_irq();
    logic [13:0] m [3] = '{E_CLK, E_TOVF, E_ROVF};
    logic [31:0] bt [3] = '{32'h80, 32'h400, 32'h800};
    wr(8'h10, 32'h4000);
    chk(32'(irq), 32'h1);
    wr(8'h10, 32'h0);
    chk(32'(irq), 32'h0);
    obs <= '{4'h0, 4'h0, 9'h0, 5'h08, 5'h03};
    wr(8'h10, 32'h1000);
    chk(32'(irq), 32'h1);
    wr(8'h10, 32'h2000);
    chk(32'(irq), 32'h1);
    obs.rx_level <= 5'h07;
    repeat (2) @(posedge sys_clk);
    #1 chk(32'(irq), 32'h0);
    obs.rx_level <= 5'h10;
    wr(8'h10, 32'h8000);
    chk(32'(irq), 32'h1);
    wr(8'h10, 32'h0);
    obs <= '0;
    for (int i = 0; i < 3; i++) begin
      pulse(m[i]);
      rd(8'h14);
      chk(d & bt[i], bt[i]);
      chk(32'(irq), 32'h0);
      wr(8'h10, bt[i]);
      chk(32'(irq), 32'h1);
      rd(8'h18);
      chk(d, bt[i]);
      wr(8'h1C, bt[i] | 32'h7F);
      chk(32'(irq), 32'h0);
      rd(8'h14);
      chk(d & bt[i], 32'h0);
    end
    $display("test irq done");
  endtask : t_irq
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results
  // ****
  // sequence and watchdog
  // ****
  initial begin
    repeat (16) @(posedge sys_clk);
    srst <= 1'b0;
    t_reset();
    t_fifo();
    t_events();
    t_tally();
    t_link();
    t_irq();
    results();
  end
  initial begin
    #2000000;
    mismatches++;
    results();
  end
endmodule : i2cst_top_tb
